// File: rtl/ctk_pkg.sv
package ctk_pkg;
  // io addresses of the touch registers
  localparam logic [7:0] ADDR_POWER_OPT = 8'h0A;
  localparam logic [7:0] ADDR_SELECT = 8'h41;
  localparam logic [7:0] ADDR_CHARGE_CTL = 8'h42;
  localparam logic [7:0] ADDR_KEY_UPPER = 8'h43;
  localparam logic [7:0] ADDR_KEY_LOWER = 8'h45;
  localparam logic [7:0] ADDR_PARAM_RSVD = 8'h46;
  localparam logic [7:0] ADDR_PARAM_TYPE = 8'h47;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h48;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h49;

  // touch_select fields
  localparam int CLK_SEL_LSB = 5;
  localparam int VREF_SEL_LSB = 2;
  localparam int DISCHG_SEL_LSB = 0;
  localparam logic [2:0] CLK_SEL_RST = 3'h0;
  localparam logic [2:0] VREF_SEL_RST = 3'h3;
  localparam logic [1:0] DISCHG_SEL_RST = 2'h0;

  // touch_charge_control fields
  localparam int CNT_EN_BIT = 7;
  localparam int CMD_LSB = 4;
  localparam logic CNT_EN_RST = 1'b0;
  localparam logic [2:0] CMD_HALT = 3'h0;
  localparam logic [2:0] CMD_MEASURE_START = 3'h1;
  localparam logic [2:0] CMD_DISCHARGE = 3'h3;
  localparam logic [2:0] STAT_READY = 3'h0;
  localparam logic [2:0] STAT_RUNNING = 3'h1;
  localparam logic [2:0] STAT_DISCHARGING = 3'h3;

  // key enables
  localparam int KEY_UPPER_W = 5;
  localparam int KEY_LOWER_W = 8;
  localparam logic [7:0] KEY_RST = 8'h00;

  // touch_param registers
  localparam logic [7:0] PARAM_RSVD_RST = 8'h00;
  localparam int TYPE_LSB = 6;
  localparam int REF_MODE_LSB = 0;
  localparam logic [1:0] TYPE_RST = 2'h0;
  localparam logic [1:0] TYPE_REGULATED = 2'h1;
  localparam logic [1:0] REF_MODE_RST = 2'h0;
  localparam logic [1:0] REF_ALWAYS_ON = 2'h1;

  // touch_power_option fields
  localparam int LDO_2V_BIT = 3;
  localparam int SUPPLY_LDO_BIT = 2;
  localparam logic POWER_BIT_RST = 1'b0;

  // pre-discharge lengths in touch clocks
  localparam logic [7:0] DISCHG_SHORT = 8'h40;
  localparam logic [7:0] DISCHG_LONG = 8'h80;

  localparam int COUNT_W = 12;
endpackage : ctk_pkg

// File: rtl/ctk_touch_sense.sv
`timescale 1ns/10ps
module ctk_touch_sense (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  // io register port
  input wire logic [7:0] IO_ADDR_I,
  input wire logic IO_WR_I,
  input wire logic IO_RD_I,
  input wire logic [7:0] IO_WDATA_I,
  output logic [7:0] IO_RDATA_O,
  // oscillators and sense comparator, asynchronous
  input wire logic LOW_SPEED_RC_OSC_I,
  input wire logic HIGH_SPEED_RC_OSC_I,
  input wire logic SENSE_TRIP_I,
  // analog front end controls
  output logic TOUCH_POWER_O,
  output logic TOUCH_DISCHARGE_O,
  output logic TOUCH_CHARGE_O,
  output logic TOUCH_MEAS_CLOCK_O,
  output logic [2:0] TOUCH_VREF_SEL_O,
  output logic [12:0] TOUCH_KEY_EN_O,
  output logic TOUCH_CAP_TO_GND_O,
  output logic TOUCH_REF_ON_O,
  output logic LDO_SEL_2V_O,
  output logic TOUCH_SUPPLY_LDO_O,
  output logic TOUCH_SUPPLY_RAIL_LDO_O
);
  import ctk_pkg::*;

  typedef enum logic [3:0] {
    ST_READY = 4'b0001,
    ST_PRE = 4'b0010,
    ST_CHARGE = 4'b0100,
    ST_DISCH = 4'b1000
  } ctk_state_e;

  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    logic [7:0] one_hot;
    one_hot = 8'h01 << sel;
    div_mask = 7'(one_hot - 8'h01);
  endfunction : div_mask

  function automatic logic [2:0] status_code(input ctk_state_e st);
    unique case (st)
      ST_READY: status_code = STAT_READY;
      ST_PRE, ST_CHARGE: status_code = STAT_RUNNING;
      ST_DISCH: status_code = STAT_DISCHARGING;
      default: status_code = STAT_READY;
    endcase
  endfunction : status_code

  ctk_state_e state_q;
  logic [2:0] clk_sel_q;
  logic [2:0] vref_sel_q;
  logic [1:0] dischg_sel_q;
  logic cnt_en_q;
  logic [KEY_UPPER_W-1:0] key_upper_q;
  logic [KEY_LOWER_W-1:0] key_lower_q;
  logic [7:0] param_rsvd_q;
  logic [1:0] type_q;
  logic [3:0] type_rsvd_q;
  logic [1:0] ref_mode_q;
  logic ldo_2v_q;
  logic supply_ldo_q;
  logic [COUNT_W-1:0] count_q;
  logic [7:0] dischg_left_q;
  logic [6:0] div_q;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] level_q;
  logic [2:0] agree;
  logic lrc_tick;
  logic hrc_tick;
  logic trip;
  logic touch_tick;
  logic wr_ctl;
  logic [2:0] wr_cmd;
  logic [7:0] dischg_len;

  // osc and comparator inputs: three stages, change taken when stages 2 and 3 agree
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      level_q <= 3'h0;
    end else begin
      sync1_q <= {SENSE_TRIP_I, HIGH_SPEED_RC_OSC_I, LOW_SPEED_RC_OSC_I};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= (agree & sync2_q) | (~agree & level_q);
    end
  end

  assign agree = ~(sync2_q ^ sync3_q);
  assign lrc_tick = agree[0] & sync2_q[0] & ~level_q[0];
  assign hrc_tick = agree[1] & sync2_q[1] & ~level_q[1];
  assign trip = level_q[2];

  // fast oscillator prescaler; the oscillators must run below a quarter of SYS_CLK
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      div_q <= 7'h00;
    end else if (hrc_tick) begin
      div_q <= div_q + 7'h01;
    end
  end

  always_comb begin
    if (clk_sel_q == 3'h0) begin
      touch_tick = lrc_tick;
    end else begin
      touch_tick = hrc_tick && ((div_q & div_mask(clk_sel_q)) == div_mask(clk_sel_q));
    end
  end

  assign wr_ctl = IO_WR_I && (IO_ADDR_I == ADDR_CHARGE_CTL);
  assign wr_cmd = IO_WDATA_I[CMD_LSB +: 3];
  // only bit 0 is decoded: codes x0 give the short interval, x1 the long one
  assign dischg_len = dischg_sel_q[0] ? DISCHG_LONG : DISCHG_SHORT;

  // configuration registers
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      clk_sel_q <= CLK_SEL_RST;
      vref_sel_q <= VREF_SEL_RST;
      dischg_sel_q <= DISCHG_SEL_RST;
      key_upper_q <= KEY_RST[KEY_UPPER_W-1:0];
      key_lower_q <= KEY_RST;
      param_rsvd_q <= PARAM_RSVD_RST;
      type_q <= TYPE_RST;
      type_rsvd_q <= 4'h0;
      ref_mode_q <= REF_MODE_RST;
      ldo_2v_q <= POWER_BIT_RST;
      supply_ldo_q <= POWER_BIT_RST;
    end else if (IO_WR_I) begin
      unique case (IO_ADDR_I)
        ADDR_SELECT: begin
          clk_sel_q <= IO_WDATA_I[CLK_SEL_LSB +: 3];
          vref_sel_q <= IO_WDATA_I[VREF_SEL_LSB +: 3];
          dischg_sel_q <= IO_WDATA_I[DISCHG_SEL_LSB +: 2];
        end
        ADDR_KEY_UPPER: key_upper_q <= IO_WDATA_I[KEY_UPPER_W-1:0];
        ADDR_KEY_LOWER: key_lower_q <= IO_WDATA_I;
        ADDR_PARAM_RSVD: param_rsvd_q <= IO_WDATA_I;
        ADDR_PARAM_TYPE: begin
          type_q <= IO_WDATA_I[TYPE_LSB +: 2];
          type_rsvd_q <= IO_WDATA_I[5:2];
          ref_mode_q <= IO_WDATA_I[REF_MODE_LSB +: 2];
        end
        ADDR_POWER_OPT: begin
          ldo_2v_q <= IO_WDATA_I[LDO_2V_BIT];
          supply_ldo_q <= IO_WDATA_I[SUPPLY_LDO_BIT];
        end
        default: ;
      endcase
    end
  end

  // counter enable bit
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cnt_en_q <= CNT_EN_RST;
    end else if (wr_ctl) begin
      cnt_en_q <= IO_WDATA_I[CNT_EN_BIT];
    end
  end

  // measurement sequencer; a valid command pre-empts whatever is in progress
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_q <= ST_READY;
      dischg_left_q <= 8'h00;
      TOUCH_POWER_O <= 1'b0;
    end else if (wr_ctl && wr_cmd == CMD_HALT) begin
      state_q <= ST_READY;
      TOUCH_POWER_O <= 1'b0;
    end else if (wr_ctl && wr_cmd == CMD_MEASURE_START) begin
      state_q <= ST_PRE;
      dischg_left_q <= dischg_len;
      TOUCH_POWER_O <= 1'b1;
    end else if (wr_ctl && wr_cmd == CMD_DISCHARGE) begin
      state_q <= ST_DISCH;
      dischg_left_q <= dischg_len;
      TOUCH_POWER_O <= 1'b1;
    end else if (touch_tick) begin
      unique case (state_q)
        ST_PRE: begin
          dischg_left_q <= dischg_left_q - 8'h01;
          if (dischg_left_q == 8'h01) begin
            state_q <= ST_CHARGE;
          end
        end
        ST_DISCH: begin
          dischg_left_q <= dischg_left_q - 8'h01;
          if (dischg_left_q == 8'h01) begin
            state_q <= ST_READY;
          end
        end
        ST_CHARGE: begin
          // a full count ends the cycle so a missing trip cannot hang it while the counter is enabled
          if (trip || count_q == {COUNT_W{1'b1}}) begin
            state_q <= ST_READY;
          end
        end
        default: ;
      endcase
    end
  end

  // charge counter
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      count_q <= '0;
    end else if (wr_ctl && (IO_WDATA_I[CNT_EN_BIT] || wr_cmd == CMD_MEASURE_START)) begin
      count_q <= '0;
    end else if (state_q == ST_CHARGE && cnt_en_q && touch_tick && !trip
                 && count_q != {COUNT_W{1'b1}}) begin
      count_q <= count_q + 12'h001;
    end
  end

  // read port, one cycle latency; write-only and unmapped addresses read zero
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      IO_RDATA_O <= 8'h00;
    end else if (IO_RD_I) begin
      unique case (IO_ADDR_I)
        ADDR_SELECT: IO_RDATA_O <= {clk_sel_q, vref_sel_q, dischg_sel_q};
        ADDR_CHARGE_CTL: IO_RDATA_O <= {cnt_en_q, status_code(state_q), 4'h0};
        ADDR_KEY_UPPER: IO_RDATA_O <= {3'h0, key_upper_q};
        ADDR_KEY_LOWER: IO_RDATA_O <= key_lower_q;
        ADDR_PARAM_RSVD: IO_RDATA_O <= param_rsvd_q;
        ADDR_PARAM_TYPE: IO_RDATA_O <= {type_q, type_rsvd_q, ref_mode_q};
        ADDR_COUNT_HIGH: IO_RDATA_O <= {4'h0, count_q[11:8]};
        ADDR_COUNT_LOW: IO_RDATA_O <= count_q[7:0];
        default: IO_RDATA_O <= 8'h00;
      endcase
    end
  end

  // front end drive
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      TOUCH_DISCHARGE_O <= 1'b0;
      TOUCH_CHARGE_O <= 1'b0;
      TOUCH_MEAS_CLOCK_O <= 1'b0;
      TOUCH_VREF_SEL_O <= VREF_SEL_RST;
      TOUCH_KEY_EN_O <= 13'h0000;
      TOUCH_CAP_TO_GND_O <= 1'b0;
      TOUCH_REF_ON_O <= 1'b0;
      LDO_SEL_2V_O <= 1'b0;
      TOUCH_SUPPLY_LDO_O <= 1'b0;
      TOUCH_SUPPLY_RAIL_LDO_O <= 1'b0;
    end else begin
      TOUCH_DISCHARGE_O <= (state_q == ST_PRE) || (state_q == ST_DISCH);
      TOUCH_CHARGE_O <= (state_q == ST_CHARGE);
      TOUCH_MEAS_CLOCK_O <= touch_tick;
      TOUCH_VREF_SEL_O <= vref_sel_q;
      TOUCH_KEY_EN_O <= {key_upper_q, key_lower_q};
      TOUCH_CAP_TO_GND_O <= (type_q == TYPE_REGULATED);
      TOUCH_REF_ON_O <= (ref_mode_q == REF_ALWAYS_ON);
      LDO_SEL_2V_O <= ldo_2v_q;
      TOUCH_SUPPLY_LDO_O <= supply_ldo_q;
      // the reference scales from the regulator only when it feeds the module
      TOUCH_SUPPLY_RAIL_LDO_O <= supply_ldo_q;
    end
  end

  // helper for pre-discharge length check
  logic [7:0] pre_ticks_q;
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pre_ticks_q <= 8'h00;
    end else if (state_q != ST_PRE) begin
      pre_ticks_q <= 8'h00;
    end else if (touch_tick) begin
      pre_ticks_q <= pre_ticks_q + 8'h01;
    end
  end

  slow_clock_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (clk_sel_q == 3'h0 && touch_tick) |-> lrc_tick)
    else $error("touch clock not from slow oscillator");

  vref_follow_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (IO_WR_I && IO_ADDR_I == ADDR_SELECT) |=> ##1 TOUCH_VREF_SEL_O == $past(IO_WDATA_I[4:2], 2))
    else $error("reference select not applied");

  pre_length_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    ($past(state_q) == ST_PRE && state_q == ST_CHARGE)
      |-> $past(pre_ticks_q) + 8'h01 == $past(dischg_len))
    else $error("pre-discharge length wrong");

  count_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (wr_ctl && IO_WDATA_I[CNT_EN_BIT]) |=> count_q == '0)
    else $error("counter not cleared on enable");

  start_cmd_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (wr_ctl && wr_cmd == CMD_MEASURE_START) |=> state_q == ST_PRE ##1 TOUCH_DISCHARGE_O)
    else $error("start command not taken");

  halt_cmd_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (wr_ctl && wr_cmd == CMD_HALT) |=> !TOUCH_POWER_O && state_q == ST_READY)
    else $error("halt command not taken");

  status_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (IO_RD_I && IO_ADDR_I == ADDR_CHARGE_CTL && state_q == ST_DISCH && !wr_ctl)
      |=> IO_RDATA_O[6:4] == STAT_DISCHARGING)
    else $error("discharging status wrong");

  key_map_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (IO_WR_I && IO_ADDR_I == ADDR_KEY_LOWER) |=> ##1 TOUCH_KEY_EN_O[7:0] == $past(IO_WDATA_I, 2))
    else $error("lower key enables misplaced");

  count_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (IO_RD_I && IO_ADDR_I == ADDR_COUNT_HIGH) |=> IO_RDATA_O == {4'h0, $past(count_q[11:8])})
    else $error("count high byte wrong");

  count_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (state_q == ST_READY && !wr_ctl) |=> $stable(count_q))
    else $error("count moved while ready");

  disch_end_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (state_q == ST_DISCH && dischg_left_q == 8'h01 && touch_tick && !wr_ctl)
      |=> state_q == ST_READY)
    else $error("discharge did not end");
endmodule : ctk_touch_sense

// File: dv/ctk_pad_model.sv
`timescale 1ns/10ps
module ctk_pad_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // front end from the block, trip threshold from the bench
  input wire logic charge_i,
  input wire logic meas_pulse_i,
  input wire logic [11:0] trip_after_i,
  // comparator back to the block
  output logic sense_trip_o
);
  logic [11:0] pulses_q;
  // cap gains one step per touch clock; drained whenever not charging
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulses_q <= 12'h000;
    end else if (!charge_i) begin
      pulses_q <= 12'h000;
    end else if (meas_pulse_i) begin
      pulses_q <= pulses_q + 12'h001;
    end
  end
  // comparator low on a drained cap, so no stale trip at the next start
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sense_trip_o <= 1'b0;
    end else begin
      sense_trip_o <= charge_i && (pulses_q + {11'h000, meas_pulse_i}) >= trip_after_i;
    end
  end
endmodule : ctk_pad_model

// File: dv/ctk_touch_sense_tb.sv
`timescale 1ns/10ps
module ctk_touch_sense_tb;
  import ctk_pkg::*;
  logic clk, nrst, wr_s, rd_s, lo_osc, hi_osc, trip, pwr, dis, chg, mclk;
  logic cap_gnd, ref_on, ldo_2v, sup_ldo, rail_ldo;
  logic [7:0] addr, wdata, rdata, q, hi, lo, osc_cnt;
  logic [2:0] vref;
  logic [12:0] keys;
  int err_count, n_tests;

  ctk_touch_sense ctk_touch_sense_i (.SYS_CLK_I(clk), .NRST_I(nrst), .IO_ADDR_I(addr),
    .IO_WR_I(wr_s), .IO_RD_I(rd_s), .IO_WDATA_I(wdata), .IO_RDATA_O(rdata),
    .LOW_SPEED_RC_OSC_I(lo_osc), .HIGH_SPEED_RC_OSC_I(hi_osc), .SENSE_TRIP_I(trip),
    .TOUCH_POWER_O(pwr), .TOUCH_DISCHARGE_O(dis), .TOUCH_CHARGE_O(chg),
    .TOUCH_MEAS_CLOCK_O(mclk), .TOUCH_VREF_SEL_O(vref), .TOUCH_KEY_EN_O(keys),
    .TOUCH_CAP_TO_GND_O(cap_gnd), .TOUCH_REF_ON_O(ref_on), .LDO_SEL_2V_O(ldo_2v),
    .TOUCH_SUPPLY_LDO_O(sup_ldo), .TOUCH_SUPPLY_RAIL_LDO_O(rail_ldo));
  ctk_pad_model ctk_pad_model_i (.clk_i(clk), .rst_n_i(nrst), .charge_i(chg),
    .meas_pulse_i(mclk), .trip_after_i(12'd37), .sense_trip_o(trip));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // fast osc every 8 clocks, slow every 16: both below a quarter of clk
  always @(posedge clk) begin
    osc_cnt <= osc_cnt + 8'h01;
    hi_osc <= osc_cnt[2];
    lo_osc <= osc_cnt[3];
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    #1 d = rdata;
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic next_pulse(output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      #1 cyc++;
    end while (mclk !== 1'b1 && cyc < 4000);
  endtask : next_pulse
  // started right after the command write, so the first tick is not missed
  task automatic count_dis(output int n);
    int g;
    n = 0;
    g = 0;
    do begin
      @(posedge clk);
      #1 g++;
    end while (dis !== 1'b1 && g < 50);
    while (dis === 1'b1 && g < 5000) begin
      if (mclk === 1'b1) n++;
      @(posedge clk);
      #1 g++;
    end
  endtask : count_dis
  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      rd(ADDR_CHARGE_CTL, q);
      k++;
    end while (q[6:4] !== STAT_READY && k < 1000);
  endtask : wait_ready
  task automatic read_count(output logic [11:0] c);
    rd(ADDR_COUNT_HIGH, hi);
    rd(ADDR_COUNT_LOW, lo);
    c = {hi[3:0], lo};
  endtask : read_count

  task automatic t_reset;
    logic [7:0] zero_regs [6];
    zero_regs = '{ADDR_KEY_UPPER, ADDR_KEY_LOWER, ADDR_PARAM_RSVD, ADDR_PARAM_TYPE,
                  ADDR_CHARGE_CTL, ADDR_POWER_OPT};
    rd(ADDR_SELECT, q);
    chk("select reset", 8'h0C, q);
    foreach (zero_regs[i]) begin
      rd(zero_regs[i], q);
      chk("register reset", 8'h00, q);
    end
    chk("vref reset", 3'h3, vref);
    chk("outputs reset", 16'h0000, {keys, ldo_2v, sup_ldo, rail_ldo});
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    wr(ADDR_SELECT, 8'hF7);
    wr(ADDR_KEY_UPPER, 8'h15);
    wr(ADDR_KEY_LOWER, 8'hA6);
    wr(ADDR_PARAM_TYPE, 8'h41);
    wr(ADDR_POWER_OPT, 8'h0C);
    settle();
    chk("vref", 3'h5, vref);
    chk("keys", 13'h15A6, keys);
    chk("type outs", 2'b11, {cap_gnd, ref_on});
    chk("power outs", 3'b111, {ldo_2v, sup_ldo, rail_ldo});
    rd(ADDR_SELECT, q);
    chk("select", 8'hF7, q);
    rd(ADDR_KEY_LOWER, q);
    chk("key lower", 8'hA6, q);
    rd(ADDR_POWER_OPT, q);
    chk("power read", 8'h00, q);
    wr(ADDR_POWER_OPT, 8'h08);
    wr(ADDR_PARAM_TYPE, 8'h01);
    settle();
    chk("power outs 2", 3'b100, {ldo_2v, sup_ldo, rail_ldo});
    chk("type outs 2", 2'b01, {cap_gnd, ref_on});
    $display("test registers done");
  endtask : t_regs

  task automatic t_measure;
    int n;
    logic [11:0] c;
    // fast system clock, so starts are only issued in regulated supply mode
    wr(ADDR_POWER_OPT, 8'h0C);
    wr(ADDR_PARAM_TYPE, 8'h41);
    wr(ADDR_SELECT, 8'h2E);
    wr(ADDR_CHARGE_CTL, 8'h90);
    fork
      count_dis(n);
      begin
        settle();
        chk("power and discharge", 2'b11, {pwr, dis});
        rd(ADDR_CHARGE_CTL, q);
        chk("running status", 8'h90, q);
      end
    join
    chk("pre-discharge ticks", 16'd64, 16'(n));
    wait_ready();
    chk("end status", 8'h80, q);
    read_count(c);
    chk("charge count", 12'd37, c);
    repeat (50) @(posedge clk);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_COUNT_LOW, 8'hFF);
    read_count(c);
    chk("count held", 12'd37, c);
    $display("test measure done");
  endtask : t_measure

  task automatic t_discharge;
    int n;
    logic [11:0] c;
    wr(ADDR_SELECT, 8'h0F);
    wr(ADDR_CHARGE_CTL, 8'h30);
    fork
      count_dis(n);
      begin
        settle();
        rd(ADDR_CHARGE_CTL, q);
        chk("discharging status", 8'h30, q);
      end
    join
    chk("discharge ticks", 16'd128, 16'(n));
    rd(ADDR_CHARGE_CTL, q);
    chk("ready after discharge", 8'h00, {q[7:4], 1'b0, chg, 2'b00});
    read_count(c);
    chk("count kept", 12'd37, c);
    $display("test discharge done");
  endtask : t_discharge

  task automatic t_halt;
    int g;
    logic [11:0] c;
    wr(ADDR_CHARGE_CTL, 8'h10);
    g = 0;
    while (chg !== 1'b1 && g < 3000) begin
      @(posedge clk);
      #1 g++;
    end
    chk("charge phase reached", 1'b1, chg);
    wr(ADDR_CHARGE_CTL, 8'h00);
    settle();
    chk("halted outs", 3'b000, {pwr, dis, chg});
    rd(ADDR_CHARGE_CTL, q);
    chk("halt status", 8'h00, q);
    read_count(c);
    chk("count without enable", 12'd0, c);
    $display("test halt done");
  endtask : t_halt

  task automatic t_clk_codes;
    int c;
    logic [2:0] v;
    for (int k = 0; k < 8; k++) begin
      v = (k == 7) ? 3'h6 : 3'(k);
      wr(ADDR_SELECT, {3'(k), v, 2'h2});
      wr(ADDR_CHARGE_CTL, 8'h30);
      next_pulse(c);
      next_pulse(c);
      chk("touch clock period", (k == 0) ? 16'd16 : 16'(8 << k), 16'(c));
      chk("vref code", v, vref);
      wr(ADDR_CHARGE_CTL, 8'h00);
    end
    $display("test clock codes done");
  endtask : t_clk_codes

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // whole run is near 10k cycles, so this only fires on a hang
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    nrst = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    osc_cnt = 8'h00;
    hi_osc = 1'b0;
    lo_osc = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_measure();
    t_discharge();
    t_halt();
    t_clk_codes();
    report_and_stop();
  end
endmodule : ctk_touch_sense_tb
